// >>> common/diag_pkg.sv
// constants, field layouts and state types for the diagnostic pattern generator
package diag_pkg;
  // clock and derived timing
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          CLK_MHZ       = 25;
  localparam int          DYN_HZ        = 610;
  localparam int          DYN_HALF_CYC  = CLK_HZ / (2 * DYN_HZ);
  localparam int          CHIPCLK_MHZ   = 4;
  localparam int          NCO_STEP      = 2 * CHIPCLK_MHZ;
  localparam int          NCO_MOD       = CLK_MHZ;
  localparam int          BAUD          = 62_000;
  localparam int          BIT_CYC       = CLK_HZ / BAUD;
  localparam int          FRAME_US      = 820;
  localparam int          FRAME_CYC     = (CLK_HZ / 1_000_000) * FRAME_US;
  localparam int          FRAME_BITS    = 10;
  localparam int          RW_PHASE_CYC  = 4;
  localparam int          STRAP_SETTLE  = 5;

  // fixed values
  localparam logic [7:0]  SERIAL_BYTE   = 8'h55;
  localparam logic [7:0]  ERR_CODE      = 8'h32;
  localparam logic [3:0]  RW_REG_ADDR   = 4'h3;
  localparam logic [7:0]  ODD_HI        = 8'haa;
  localparam logic [7:0]  EVEN_HI       = 8'h55;

  // port direction masks while the diagnostic runs
  localparam logic [7:0]  PORT_ZERO_OE  = 8'h0f;
  localparam logic [7:0]  PORT_ONE_OE   = 8'hff;
  localparam logic [7:0]  PORT_TWO_OE   = 8'h00;
  localparam logic [7:0]  PORT_THREE_OE = 8'hc0;

  // register map
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_SEED      = 8'h04;
  localparam logic [7:0]  SEED_RST      = 8'h00;
  localparam int          ST_ACTIVE_LSB = 0;
  localparam int          ST_MODE_LSB   = 1;
  localparam int          ST_DIR_LSB    = 4;
  localparam int          ST_CODE_LSB   = 8;
  localparam int          ST_DATA_LSB   = 16;

  typedef enum logic [2:0]
  {
    M_OFF   = 3'b000,
    M_RW    = 3'b001,
    M_DYN   = 3'b011,
    M_STAT0 = 3'b010,
    M_STAT1 = 3'b110
  } mode_t;

  typedef enum logic [1:0]
  {
    RW_SETUP   = 2'b00,
    RW_STROBE  = 2'b01,
    RW_RELEASE = 2'b11,
    RW_NEXT    = 2'b10
  } rw_state_t;
endpackage

// >>> common/ser_if.sv
// start/busy/line bundle between the frame timer and the serial sender
`timescale 1ns/1ps
interface ser_if;
  logic start;
  logic busy;
  logic txd;
  modport tx  (input start, output busy, output txd);
  modport ctl (output start, input busy, input txd);
endinterface

// >>> core/serial_byte_tx.sv
// serial sender of the fixed test byte, one start bit, eight data bits, one stop bit
`timescale 1ns/1ps
module serial_byte_tx
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control link
  ser_if.tx         link
);
  import diag_pkg::*;

  logic [8:0] baud_r;
  logic [3:0] left_r;
  logic [8:0] shift_r;
  logic       busy_r;
  logic       txd_r;

  wire        baud_end = baud_r == 9'(BIT_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      baud_r  <= 9'h000;
      left_r  <= 4'h0;
      shift_r <= 9'h1ff;
      busy_r  <= 1'b0;
      txd_r   <= 1'b1;
    end
    else if (!busy_r)
    begin
      if (link.start)
      begin
        busy_r  <= 1'b1;
        txd_r   <= 1'b0;
        shift_r <= {1'b1, SERIAL_BYTE};
        left_r  <= 4'(FRAME_BITS - 1);
        baud_r  <= 9'h000;
      end
    end
    else if (baud_end)
    begin
      baud_r <= 9'h000;
      if (left_r == 4'h0)
      begin
        busy_r <= 1'b0;
        txd_r  <= 1'b1;
      end
      else
      begin
        txd_r   <= shift_r[0];
        shift_r <= {1'b1, shift_r[8:1]};
        left_r  <= left_r - 4'h1;
      end
    end
    else
    begin
      baud_r <= baud_r + 9'h001;
    end
  end

  assign link.busy = busy_r;
  assign link.txd  = txd_r;

  a_tx_start_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (link.start && !busy_r) |=> !txd_r [*8])
    else $error("start bit not held low");

  a_tx_bit_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (busy_r && !baud_end) |=> $stable(txd_r))
    else $error("serial bit changed inside its bit time");
endmodule

// >>> core/diag_pattern_gen.sv
// diagnostic pattern generator for the bus option board controller
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - jumper shorted at power-up enters diagnostics and shows error code 50.
// - diagnostics end only by removing jumper and cycling power.
// - three switches pick one of four modes; 101 gives odd bits high.
// - static mode holds outputs constant per middle switch; 111 drives even bits high.
// - top 1, low 0 gives dynamic mode, 610 Hz square at half duty.
// - in dynamic mode odd bits run in antiphase to even bits.
// - top 0 gives read/write mode; transfers happen while strobe low, direction line set.
// - read/write mode presents address 3 and increments data after each access.
// - port zero low nibble and all of port one are driven in every mode.
// - port zero bits 4-7, port two, port three bits 1-4 never driven.
// - a 4 MHz chip clock leaves on port three bit 6 in every mode.
// - byte 55 hex goes out serially every 820 us at 62000 baud.
module diag_pattern_gen
#(
  parameter int DYN_HALF_CYC_P = diag_pkg::DYN_HALF_CYC,
  parameter int FRAME_CYC_P    = diag_pkg::FRAME_CYC
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // jumper and mode switches
  input  wire logic        diag_jumper_point_b,
  output logic             diag_jumper_point_a,
  input  wire logic        mode_switch_top,
  input  wire logic        mode_switch_mid,
  input  wire logic        mode_switch_low,
  // front display
  output logic      [7:0]  error_code,
  // controller ports
  output logic      [3:0]  port_zero_out,
  output logic      [7:0]  port_zero_oe,
  output logic      [7:0]  port_one_out,
  output logic      [7:0]  port_one_oe,
  output logic      [7:0]  port_two_oe,
  output logic             chip_clk,
  output logic             serial_out,
  output logic      [7:0]  port_three_oe,
  // interface chip strobes
  output logic             chip_rw,
  output logic             chip_data_strobe_n
);
  import diag_pkg::*;

  // pin synchronisers: a change counts when stages two and three agree
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic [3:0]  pin_s3_r;
  logic [3:0]  pin_lvl_r;
  wire  [3:0]  pin_raw = {diag_jumper_point_b, mode_switch_top, mode_switch_mid, mode_switch_low};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_r  <= 4'hf;
      pin_s2_r  <= 4'hf;
      pin_s3_r  <= 4'hf;
      pin_lvl_r <= 4'hf;
    end
    else
    begin
      pin_s1_r  <= pin_raw;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r | pin_s3_r));
    end
  end

  // jumper strap, caught once after reset release and then frozen
  logic [2:0]  settle_r;
  logic        strap_done_r;
  logic        diag_active_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_r      <= 3'h0;
      strap_done_r  <= 1'b0;
      diag_active_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      if (settle_r == 3'(STRAP_SETTLE - 1))
      begin
        strap_done_r  <= 1'b1;
        diag_active_r <= ~pin_lvl_r[3];
      end
      else
      begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  // mode decode from the filtered switches
  wire         sw_top = pin_lvl_r[2];
  wire         sw_mid = pin_lvl_r[1];
  wire         sw_low = pin_lvl_r[0];
  mode_t       sw_mode;
  mode_t       mode_r;

  assign sw_mode = !diag_active_r ? M_OFF   :
                   !sw_top        ? M_RW    :
                   !sw_low        ? M_DYN   :
                   sw_mid         ? M_STAT1 :
                                    M_STAT0;

  // square wave timebase; a full period is one pattern cycle
  logic [14:0] wave_cnt_r;
  logic        wave_r;
  wire         wave_wrap    = wave_cnt_r == 15'(DYN_HALF_CYC_P - 1);
  wire         pattern_tick = (wave_wrap & wave_r) | (mode_r == M_OFF);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wave_cnt_r <= 15'h0000;
      wave_r     <= 1'b0;
      mode_r     <= M_OFF;
    end
    else
    begin
      if (!diag_active_r)
      begin
        wave_cnt_r <= 15'h0000;
        wave_r     <= 1'b0;
      end
      else if (wave_wrap)
      begin
        wave_cnt_r <= 15'h0000;
        wave_r     <= ~wave_r;
      end
      else
      begin
        wave_cnt_r <= wave_cnt_r + 15'h0001;
      end
      if (pattern_tick)
      begin
        mode_r <= sw_mode;
      end
    end
  end

  // chip clock: fractional divider, average rate exact
  logic [4:0]  nco_r;
  wire  [5:0]  nco_sum  = {1'b0, nco_r} + 6'(NCO_STEP);
  wire         nco_wrap = nco_sum >= 6'(NCO_MOD);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nco_r    <= 5'h00;
      chip_clk <= 1'b0;
    end
    else if (!diag_active_r)
    begin
      nco_r    <= 5'h00;
      chip_clk <= 1'b0;
    end
    else
    begin
      nco_r <= nco_wrap ? 5'(nco_sum - 6'(NCO_MOD)) : nco_sum[4:0];
      if (nco_wrap)
      begin
        chip_clk <= ~chip_clk;
      end
    end
  end

  // serial frame timer and sender
  logic [14:0] frame_cnt_r;
  logic        start_r;
  wire         frame_wrap = frame_cnt_r == 15'(FRAME_CYC_P - 1);
  ser_if       ser ();

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_cnt_r <= 15'h0000;
      start_r     <= 1'b0;
      serial_out  <= 1'b1;
    end
    else
    begin
      frame_cnt_r <= (frame_wrap | !diag_active_r) ? 15'h0000 : frame_cnt_r + 15'h0001;
      start_r     <= diag_active_r & frame_wrap;
      serial_out  <= diag_active_r ? ser.txd : 1'b1;
    end
  end

  assign ser.start = start_r;

  serial_byte_tx serial_byte_tx_i
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .link    (ser.tx)
  );

  // read/write cycling toward the interface chip
  rw_state_t   rw_state_r;
  rw_state_t   rw_nxt;
  logic [1:0]  phase_r;
  logic        rw_dir_r;
  logic [7:0]  data_r;
  logic [7:0]  seed_r;
  logic        bus_wr_r;
  logic [7:0]  bus_addr_r;
  wire         rw_run      = mode_r == M_RW;
  wire         phase_end   = phase_r == 2'(RW_PHASE_CYC - 1);
  wire         access_done = rw_run & (rw_state_r == RW_NEXT) & phase_end;
  // a strobe already under way runs to its full width when the mode changes
  wire         strobe_on   = rw_state_r == RW_STROBE;
  wire         seed_wr     = bus_wr_r & (bus_addr_r == REG_SEED);

  always_comb
  begin
    unique case (rw_state_r)
      RW_SETUP:   rw_nxt = RW_STROBE;
      RW_STROBE:  rw_nxt = RW_RELEASE;
      RW_RELEASE: rw_nxt = RW_NEXT;
      RW_NEXT:    rw_nxt = RW_SETUP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rw_state_r <= RW_SETUP;
      phase_r    <= 2'h0;
      rw_dir_r   <= 1'b0;
      data_r     <= SEED_RST;
    end
    else
    begin
      if (!rw_run && !strobe_on)
      begin
        rw_state_r <= RW_SETUP;
        phase_r    <= 2'h0;
      end
      else
      begin
        phase_r <= phase_end ? 2'h0 : phase_r + 2'h1;
        if (phase_end)
        begin
          rw_state_r <= rw_nxt;
        end
      end
      if (access_done)
      begin
        rw_dir_r <= ~rw_dir_r;
      end
      if (seed_wr)
      begin
        data_r <= hwdata[7:0];
      end
      else if (access_done)
      begin
        data_r <= data_r + 8'h01;
      end
    end
  end

  // port patterns
  wire         mode_on = mode_r != M_OFF;
  wire         even_hi = (mode_r == M_STAT1) | ((mode_r == M_DYN) & wave_r);
  wire  [7:0]  par_pat = even_hi ? EVEN_HI : ODD_HI;
  wire  [3:0]  port_zero_nxt = rw_run ? RW_REG_ADDR : par_pat[3:0];
  wire  [7:0]  port_one_nxt  = rw_run ? data_r : par_pat;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_zero_out       <= 4'h0;
      port_one_out        <= 8'h00;
      port_zero_oe        <= 8'h00;
      port_one_oe         <= 8'h00;
      port_two_oe         <= 8'h00;
      port_three_oe       <= 8'h00;
      chip_rw             <= 1'b0;
      chip_data_strobe_n  <= 1'b1;
      error_code          <= 8'h00;
      diag_jumper_point_a <= 1'b0;
    end
    else
    begin
      port_zero_out       <= mode_on ? port_zero_nxt : 4'h0;
      port_one_out        <= mode_on ? port_one_nxt : 8'h00;
      port_zero_oe        <= mode_on ? PORT_ZERO_OE : 8'h00;
      port_one_oe         <= mode_on ? PORT_ONE_OE : 8'h00;
      port_two_oe         <= PORT_TWO_OE;
      port_three_oe       <= mode_on ? PORT_THREE_OE : 8'h00;
      chip_rw             <= rw_dir_r;
      chip_data_strobe_n  <= ~strobe_on;
      error_code          <= diag_active_r ? ERR_CODE : 8'h00;
      diag_jumper_point_a <= 1'b0;
    end
  end

  // ahb-lite slave: zero wait states, always OKAY
  wire         ahb_take  = hsel & htrans[1] & hready;
  wire  [7:0]  seed_view = seed_wr ? hwdata[7:0] : seed_r;
  wire  [31:0] status_word = (32'(data_r) << ST_DATA_LSB) | (32'(error_code) << ST_CODE_LSB) |
                             (32'(rw_dir_r) << ST_DIR_LSB) | (32'(mode_r) << ST_MODE_LSB) |
                             (32'(diag_active_r) << ST_ACTIVE_LSB);
  wire  [31:0] rd_word = (haddr[7:0] == REG_STATUS) ? status_word :
                         (haddr[7:0] == REG_SEED)   ? {24'h000000, seed_view} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_wr_r   <= 1'b0;
      bus_addr_r <= 8'h00;
      seed_r     <= SEED_RST;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else
    begin
      bus_wr_r   <= ahb_take & hwrite;
      bus_addr_r <= haddr[7:0];
      seed_r     <= seed_view;
      hrdata     <= (ahb_take & !hwrite) ? rd_word : 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_error_code_shown: assert property (diag_active_r |=> error_code == ERR_CODE)
    else $error("error code not shown in diagnostics");
  a_diag_no_exit: assert property (diag_active_r |=> diag_active_r)
    else $error("diagnostics left without power cycle");
  a_static_odd_hi: assert property ((mode_r == M_STAT0 && !pattern_tick) |=> port_zero_out == 4'ha)
    else $error("static odd pattern wrong");
  a_static_even_hi: assert property ((mode_r == M_STAT1 && !pattern_tick) |=> port_one_out == EVEN_HI)
    else $error("static even pattern wrong");
  a_dyn_half_period: assert property ((diag_active_r && !wave_wrap) |=> $stable(wave_r))
    else $error("square wave toggled early");
  a_dyn_antiphase: assert property ((mode_r == M_DYN && !pattern_tick) |=>
    port_one_out[0] != port_one_out[1] && port_one_out == {4{port_one_out[1:0]}})
    else $error("dynamic bits not in antiphase");
  a_strobe_width: assert property ($fell(chip_data_strobe_n) |-> !chip_data_strobe_n [*4] ##1 chip_data_strobe_n)
    else $error("data strobe width wrong");
  a_rw_address: assert property ((rw_run && !pattern_tick) |=> port_zero_out == RW_REG_ADDR)
    else $error("read/write address not 3");
  a_data_step: assert property ((access_done && !seed_wr) |=> data_r == $past(data_r) + 8'h01)
    else $error("data byte not incremented");
  a_driven_bits: assert property (mode_on |=> port_zero_oe[3:0] == 4'hf && port_one_oe == 8'hff)
    else $error("address or data bits not driven");
  a_never_driven: assert property (port_zero_oe[7:4] == 4'h0 && port_two_oe == 8'h00 &&
    port_three_oe[4:1] == 4'h0)
    else $error("forbidden port bit driven");
  a_chip_clock_runs: assert property ((diag_active_r && strap_done_r) |-> ##[1:4] $changed(chip_clk))
    else $error("chip clock stalled");
  a_mode_holds: assert property (!pattern_tick |=> $stable(mode_r))
    else $error("mode changed outside a pattern cycle boundary");
endmodule

// >>> test/chip_link_model.sv
// behavioural model of the bus interface chip on the read/write link
`timescale 1ns/1ps
module chip_link_model
(
  // clock
  input  wire logic       hclk,
  // link from the generator
  input  wire logic       chip_data_strobe_n,
  input  wire logic       chip_rw,
  input  wire logic [3:0] port_zero_out,
  input  wire logic [7:0] port_one_out,
  // one record per finished access
  output logic            seen,
  output logic      [3:0] addr,
  output logic      [7:0] data,
  output logic            dir,
  output int              low_cyc
);
  int cnt = 0;

  initial seen = 1'b0;

  // the chip takes a transfer only while the strobe is low, direction from chip_rw
  always @(posedge hclk)
  begin
    seen <= 1'b0;
    if (chip_data_strobe_n === 1'b0)
    begin
      if (cnt == 0)
      begin
        addr <= port_zero_out;
        data <= port_one_out;
        dir  <= chip_rw;
      end
      cnt <= cnt + 1;
    end
    else if (cnt != 0)
    begin
      seen    <= 1'b1;
      low_cyc <= cnt;
      cnt     <= 0;
    end
  end
endmodule

// >>> test/bus_option_diag_pattern_gen_bench.sv
// self-checking bench for the diagnostic pattern generator
`timescale 1ns/1ps
module bus_option_diag_pattern_gen_bench;
  import diag_pkg::*;
  localparam int DH = 20;
  localparam int FR = 6000;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic        top = 1'b1;
  logic        mid = 1'b0;
  logic        low = 1'b1;
  logic        shorted = 1'b1;
  logic [31:0] rs = 32'h660d;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        point_a;
  logic [7:0]  error_code;
  logic [3:0]  pz;
  logic [7:0]  p0oe;
  logic [7:0]  po;
  logic [7:0]  p1oe;
  logic [7:0]  p2oe;
  logic [7:0]  p3oe;
  logic        chip_clk;
  logic        serial_out;
  logic        chip_rw;
  logic        strobe_n;
  logic        seen;
  logic [3:0]  m_addr;
  logic [7:0]  m_data;
  logic        m_dir;
  int          m_low;
  logic [8:0]  notes[$];
  logic [8:0]  note;
  int          failures = 0;
  int          checks = 0;
  int          popped = 0;
  int          cyc = 0;
  wire logic   hready = hreadyout;
  // open jumper floats high through its pull-up
  wire logic   point_b = shorted ? point_a : 1'b1;

  always #20 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  diag_pattern_gen #(.DYN_HALF_CYC_P(DH), .FRAME_CYC_P(FR)) diag_pattern_gen_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .diag_jumper_point_b(point_b), .diag_jumper_point_a(point_a),
    .mode_switch_top(top), .mode_switch_mid(mid), .mode_switch_low(low), .error_code(error_code),
    .port_zero_out(pz), .port_zero_oe(p0oe), .port_one_out(po), .port_one_oe(p1oe),
    .port_two_oe(p2oe), .chip_clk(chip_clk), .serial_out(serial_out), .port_three_oe(p3oe),
    .chip_rw(chip_rw), .chip_data_strobe_n(strobe_n)
  );

  chip_link_model chip_link_model_i
  (
    .hclk(hclk), .chip_data_strobe_n(strobe_n), .chip_rw(chip_rw), .port_zero_out(pz),
    .port_one_out(po), .seen(seen), .addr(m_addr), .data(m_data), .dir(m_dir), .low_cyc(m_low)
  );

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic timeout();
    failures++;
    $display("mismatch wait expected done seen timeout");
    stop_test();
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do
    begin
      ticks(1);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) timeout();
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("bus response", 32'h0, 32'(hresp));
  endtask

  task automatic set_mode(input logic [2:0] sw, input logic [2:0] code);
    logic [31:0] st;
    int i;
    {top, mid, low} <= sw;
    i = 0;
    do
    begin
      ahb(1'b0, 32'(REG_STATUS), 32'h0, st);
      i++;
    end
    while (st[3:1] !== code && i < 60);
    check("mode code", 32'(code), 32'(st[3:1]));
    check("diag active and code", 32'h3201, {16'h0, st[15:8], 7'h0, st[0]});
    ticks(3);
  endtask

  task automatic hold_check(input logic [7:0] e);
    int bad;
    bad = 0;
    repeat (50)
    begin
      ticks(1);
      if ({pz, po} !== {e[3:0], e}) bad++;
    end
    check("static bad cycles", 32'h0, 32'(bad));
  endtask

  task automatic serial_frame(output int st);
    logic [9:0] got;
    int h;
    int i;
    h = 0;
    i = 0;
    while (!(h > BIT_CYC && serial_out === 1'b0) && i < 3 * FR)
    begin
      h = (serial_out === 1'b1) ? h + 1 : 0;
      ticks(1);
      i++;
    end
    if (i >= 3 * FR) timeout();
    st = cyc;
    ticks(BIT_CYC / 2);
    for (int b = 0; b < 10; b++)
    begin
      got[b] = serial_out;
      ticks(BIT_CYC);
    end
    check("serial frame", 32'h2aa, 32'(got));
  endtask

  // partner records are matched against the oldest note
  always @(posedge hclk)
    if (seen === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      check("access address", 32'h3, 32'(m_addr));
      check("access data", 32'(note[7:0]), 32'(m_data));
      check("access direction", 32'(note[8]), 32'(m_dir));
      check("strobe low cycles", 32'(RW_PHASE_CYC), 32'(m_low));
      popped++;
    end

  initial
  begin
    logic [31:0] rd;
    logic [31:0] r;
    logic [7:0]  seed;
    int          n[3];
    int          s0;
    int          s1;
    ticks(4);
    hresetn <= 1'b1;
    ticks(10);
    check("error code", 32'h32, 32'(error_code));
    check("jumper low side", 32'h0, 32'(point_a));
    check("oe masks", 32'h0fff00c0, {p0oe, p1oe, p2oe, p3oe});
    ahb(1'b0, 32'(REG_SEED), 32'h0, rd);
    check("seed reset", 32'(SEED_RST), rd);
    r = rnd();
    seed = 8'hfc | {6'h0, r[1:0]};
    ahb(1'b1, 32'(REG_SEED), {r[31:8], seed}, rd);
    ahb(1'b0, 32'(REG_SEED), 32'h0, rd);
    check("seed readback", 32'(seed), rd);
    ahb(1'b1, 32'h8, r, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    set_mode(3'b101, M_STAT0);
    hold_check(8'haa);
    set_mode(3'b111, M_STAT1);
    hold_check(8'h55);
    r = rnd();
    set_mode({1'b1, r[0], 1'b0}, M_DYN);
    for (int k = 0; k < 3; k++)
    begin
      rd = {24'h0, po};
      n[k] = 0;
      while (po === rd[7:0] && n[k] < 4 * DH)
      begin
        ticks(1);
        n[k]++;
      end
      check("dynamic phase", 32'h1, 32'((po === 8'haa || po === 8'h55) && pz === po[3:0]));
    end
    check("dynamic half one", 32'(DH), 32'(n[1]));
    check("dynamic half two", 32'(DH), 32'(n[2]));
    serial_frame(s0);
    serial_frame(s1);
    check("frame spacing", 32'(FR), 32'(s1 - s0));
    for (int k = 0; k < 6; k++) notes.push_back({k[0], 8'(seed + k)});
    r = rnd();
    set_mode({1'b0, r[1:0]}, M_RW);
    s0 = 0;
    rd = 32'(chip_clk);
    // fixed window: 100 cycles at 25 MHz hold 32 toggles of a 4 MHz clock
    for (int i = 0; i < 100; i++)
    begin
      ticks(1);
      if (chip_clk !== rd[0]) s0++;
      rd = 32'(chip_clk);
    end
    for (int i = 0; i < 400 && popped < 6; i++) ticks(1);
    notes.delete();
    check("accesses seen", 32'h6, 32'(popped));
    check("chip clock toggles", 32'h1, 32'(s0 >= 31 && s0 <= 35));
    set_mode(3'b101, M_STAT0);
    shorted <= 1'b0;
    hresetn <= 1'b0;
    hsel <= 1'b0;
    ticks(4);
    hresetn <= 1'b1;
    ticks(10);
    check("error code open", 32'h0, 32'(error_code));
    check("oe open", 32'h0, {p0oe, p1oe, p2oe, p3oe});
    stop_test();
  end
endmodule
